//--- rtl/cardbus_socket_event_mask.sv
// Bus target for one socket's register group with its event core
module cardbus_socket_event_mask (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Bus pins, all synchronous to sys_clk
  input  wire logic        frame_n,
  input  wire logic        irdy_n,
  input  wire logic        idsel,
  input  wire logic [3:0]  cbe_n,
  input  wire logic [31:0] ad_in,
  output logic      [31:0] ad_out,
  output logic             ad_oe,
  output logic             trdy_n,
  output logic             trdy_oe,
  output logic             devsel_n,
  output logic             devsel_oe,
  output logic             stop_n,
  output logic             stop_oe,
  output logic             par_out,
  output logic             par_oe,
  // Socket lines
  input  wire logic        card_detect_line_one,
  input  wire logic        card_detect_line_two,
  input  wire logic        card_status_state,
  input  wire logic        socket_powered_state,
  input  wire logic        card_is_16bit,
  input  wire logic        card_reset_active,
  output logic             status_change_interrupt
);
  import socket_pkg::*;

  // ==========================================================
  // Event core
  socket_reg_if regs ();

  socket_event_core u_core (
    .sys_clk              (sys_clk),
    .rst                  (rst),
    .card_detect_line_one (card_detect_line_one),
    .card_detect_line_two (card_detect_line_two),
    .card_status_state    (card_status_state),
    .socket_powered_state (socket_powered_state),
    .card_is_16bit        (card_is_16bit),
    .card_reset_active    (card_reset_active),
    .regs                 (regs.core)
  );

  // Straight from the core's flip-flop
  assign status_change_interrupt = regs.irq_q;

  // ==========================================================
  // Target state
  tgt_state_t  state_r;
  tgt_state_t  state_nxt;
  logic        bus_idle_r;
  logic        bus_idle_nxt;
  logic        is_cfg_r;
  logic        is_cfg_nxt;
  logic        is_read_r;
  logic        is_read_nxt;
  logic [7:0]  off_r;
  logic [7:0]  off_nxt;
  logic [31:0] bar_r;
  logic [31:0] bar_nxt;
  logic [31:0] cmd_r;
  logic [31:0] cmd_nxt;
  logic [31:0] ad_out_nxt;
  logic        ad_oe_nxt;
  logic        trdy_n_nxt;
  logic        devsel_n_nxt;
  logic        strobe_oe_nxt;
  logic        par_out_nxt;
  logic        par_oe_nxt;
  logic        wr_stb_r;
  logic        wr_stb_nxt;
  logic [7:0]  wr_off_r;
  logic [7:0]  wr_off_nxt;
  logic [31:0] wr_data_r;
  logic [31:0] wr_data_nxt;
  logic [3:0]  wr_be_r;
  logic [3:0]  wr_be_nxt;

  // ==========================================================
  // Helpers
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    merge_bytes = res;
  endfunction : merge_bytes

  function automatic logic [31:0] socket_word(input logic [7:0] off,
                                              input logic [3:0] evt,
                                              input logic [3:0] msk,
                                              input logic [5:0] st);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (off == SOCK_EVENT_OFF) begin
      w[3:0] = evt;
    end else if (off == SOCK_MASK_OFF) begin
      w[3:0] = msk;
    end else if (off == SOCK_STATE_OFF) begin
      // Current levels, apart from the change flags
      w = STATE_VCC_SUPPORT;
      w[3:0] = st[3:0];
      w[STATE_16BIT_BIT] = st[4];
      w[STATE_CB_BIT]    = ~st[4];
    end
    // Control, reserved, power management and force-event read zero
    socket_word = w;
  endfunction : socket_word

  // ==========================================================
  // Target sequencing
  // Single-word target: every access ends with disconnect-with-data,
  // trading burst speed for a small state machine.
  always_comb begin
    logic       addr_phase;
    logic       mem_hit;
    logic       cfg_hit;
    logic       read_cmd;
    logic [3:0] be;
    addr_phase    = bus_idle_r & ~frame_n;
    be            = ~cbe_n;
    read_cmd      = (cbe_n == CMD_MEM_RD) || (cbe_n == CMD_CFG_RD);
    mem_hit       = ((cbe_n == CMD_MEM_RD) || (cbe_n == CMD_MEM_WR)) && cmd_r[CMD_MEM_BIT]
                    && (ad_in[31:BAR_LOW_BIT] == bar_r[31:BAR_LOW_BIT]);
    cfg_hit       = ((cbe_n == CMD_CFG_RD) || (cbe_n == CMD_CFG_WR)) && idsel
                    && (ad_in[1:0] == 2'b00);
    bus_idle_nxt  = frame_n & irdy_n;
    state_nxt     = state_r;
    is_cfg_nxt    = is_cfg_r;
    is_read_nxt   = is_read_r;
    off_nxt       = off_r;
    bar_nxt       = bar_r;
    cmd_nxt       = cmd_r;
    ad_out_nxt    = ad_out;
    ad_oe_nxt     = ad_oe;
    trdy_n_nxt    = trdy_n;
    devsel_n_nxt  = devsel_n;
    strobe_oe_nxt = devsel_oe;
    par_out_nxt   = par_out;
    par_oe_nxt    = 1'b0;
    wr_stb_nxt    = 1'b0;
    wr_off_nxt    = wr_off_r;
    wr_data_nxt   = wr_data_r;
    wr_be_nxt     = wr_be_r;
    case (state_r)
      ST_IDLE: begin
        strobe_oe_nxt = 1'b0;
        if (addr_phase && (mem_hit || cfg_hit)) begin
          state_nxt     = ST_ACK;
          is_cfg_nxt    = cfg_hit;
          is_read_nxt   = read_cmd;
          off_nxt       = ad_in[7:0];
          strobe_oe_nxt = 1'b1;
          devsel_n_nxt  = 1'b0;
          trdy_n_nxt    = 1'b0;
          ad_oe_nxt     = read_cmd;
          if (cfg_hit) begin
            if (ad_in[7:0] == CFG_BAR_OFF) begin
              ad_out_nxt = bar_r;
            end else if (ad_in[7:0] == CFG_CMD_OFF) begin
              ad_out_nxt = cmd_r;
            end else begin
              ad_out_nxt = 32'h0000_0000;
            end
          end else begin
            ad_out_nxt = socket_word(ad_in[7:0], regs.event_q, regs.mask_q, regs.state_q);
          end
        end
      end
      ST_ACK: begin
        if (!irdy_n) begin
          state_nxt    = ST_TURN;
          devsel_n_nxt = 1'b1;
          trdy_n_nxt   = 1'b1;
          ad_oe_nxt    = 1'b0;
          par_out_nxt  = ^{ad_out, cbe_n};
          par_oe_nxt   = is_read_r;
          if (!is_read_r && is_cfg_r) begin
            if (off_r == CFG_BAR_OFF) begin
              bar_nxt = merge_bytes(bar_r, ad_in, be);
              bar_nxt[BAR_LOW_BIT-1:0] = BAR_RESET[BAR_LOW_BIT-1:0];
            end else if (off_r == CFG_CMD_OFF) begin
              cmd_nxt = merge_bytes(cmd_r, ad_in, be);
            end
          end else if (!is_read_r) begin
            wr_stb_nxt  = 1'b1;
            wr_off_nxt  = off_r;
            wr_data_nxt = ad_in;
            wr_be_nxt   = be;
          end
        end
      end
      ST_TURN: begin
        // Strobes driven high for one cycle before release
        state_nxt     = ST_IDLE;
        strobe_oe_nxt = 1'b0;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r    <= ST_IDLE;
      bus_idle_r <= 1'b1;
      is_cfg_r   <= 1'b0;
      is_read_r  <= 1'b0;
      off_r      <= 8'h00;
      bar_r      <= BAR_RESET;
      cmd_r      <= CMD_RESET;
      ad_out     <= 32'h0000_0000;
      ad_oe      <= 1'b0;
      trdy_n     <= 1'b1;
      trdy_oe    <= 1'b0;
      devsel_n   <= 1'b1;
      devsel_oe  <= 1'b0;
      stop_n     <= 1'b1;
      stop_oe    <= 1'b0;
      par_out    <= 1'b0;
      par_oe     <= 1'b0;
      wr_stb_r   <= 1'b0;
      wr_off_r   <= 8'h00;
      wr_data_r  <= 32'h0000_0000;
      wr_be_r    <= 4'h0;
    end else begin
      state_r    <= state_nxt;
      bus_idle_r <= bus_idle_nxt;
      is_cfg_r   <= is_cfg_nxt;
      is_read_r  <= is_read_nxt;
      off_r      <= off_nxt;
      bar_r      <= bar_nxt;
      cmd_r      <= cmd_nxt;
      ad_out     <= ad_out_nxt;
      ad_oe      <= ad_oe_nxt;
      trdy_n     <= trdy_n_nxt;
      trdy_oe    <= strobe_oe_nxt;
      devsel_n   <= devsel_n_nxt;
      devsel_oe  <= strobe_oe_nxt;
      stop_n     <= trdy_n_nxt;
      stop_oe    <= strobe_oe_nxt;
      par_out    <= par_out_nxt;
      par_oe     <= par_oe_nxt;
      wr_stb_r   <= wr_stb_nxt;
      wr_off_r   <= wr_off_nxt;
      wr_data_r  <= wr_data_nxt;
      wr_be_r    <= wr_be_nxt;
    end
  end

  assign regs.wr_stb  = wr_stb_r;
  assign regs.wr_off  = wr_off_r;
  assign regs.wr_data = wr_data_r;
  assign regs.wr_be   = wr_be_r;

endmodule : cardbus_socket_event_mask

//--- include/socket_pkg.sv
// Constants and types shared by the socket status-change logic
// Notes on behaviour
// - Per-socket base register at configuration 10h
// - Decode socket words 00h to 20h
// - Event bits flag change; state read separately
// - Writing one clears event bit; zero keeps
// - Force-event one sets matching event bit
// - Bus reset clears every event bit
// - Leaving card reset re-sets still-asserted events
// - Event and mask bits 31-4 read zero
// - Bit 3 sets on powered-state change
// - Bits 2, 1 set on detect changes
// - 32-bit card: bit 0 on rise only
// - 16-bit card: bit 0 on both edges
// - Mask gates interrupt only, not event setting
// - Mask bit 3 enables power-change interrupt
// - Mask 2-1: 11 enables detects, else disabled
// - Mask bit 0 enables status-change interrupt
package socket_pkg;

  // ==========================================================
  // Configuration space
  localparam logic [7:0]  CFG_CMD_OFF    = 8'h04;
  localparam logic [7:0]  CFG_BAR_OFF    = 8'h10;
  localparam int          CMD_MEM_BIT    = 1;
  localparam int          BAR_LOW_BIT    = 12;
  localparam logic [31:0] BAR_RESET      = 32'h0000_0000;
  localparam logic [31:0] CMD_RESET      = 32'h0000_0000;

  // ==========================================================
  // Socket register offsets
  localparam logic [7:0]  SOCK_EVENT_OFF = 8'h00;
  localparam logic [7:0]  SOCK_MASK_OFF  = 8'h04;
  localparam logic [7:0]  SOCK_STATE_OFF = 8'h08;
  localparam logic [7:0]  SOCK_FORCE_OFF = 8'h0C;
  localparam logic [7:0]  SOCK_CTRL_OFF  = 8'h10;
  localparam logic [7:0]  SOCK_PM_OFF    = 8'h20;

  // ==========================================================
  // Event and mask fields
  localparam int          EVT_WIDTH      = 4;
  localparam int          EVT_POWER_BIT  = 3;
  localparam int          EVT_DET2_BIT   = 2;
  localparam int          EVT_DET1_BIT   = 1;
  localparam int          EVT_CSTS_BIT   = 0;
  localparam logic [3:0]  EVT_RESET      = 4'h0;
  localparam logic [3:0]  MASK_RESET     = 4'h0;

  // ==========================================================
  // Present-state fields
  localparam logic [31:0] STATE_VCC_SUPPORT = 32'h3000_0000;
  localparam int          STATE_CB_BIT      = 5;
  localparam int          STATE_16BIT_BIT   = 4;

  // ==========================================================
  // Bus commands
  localparam logic [3:0]  CMD_MEM_RD     = 4'h6;
  localparam logic [3:0]  CMD_MEM_WR     = 4'h7;
  localparam logic [3:0]  CMD_CFG_RD     = 4'hA;
  localparam logic [3:0]  CMD_CFG_WR     = 4'hB;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACK  = 2'b01,
    ST_TURN = 2'b10
  } tgt_state_t;

endpackage : socket_pkg

//--- include/socket_reg_if.sv
// Register strobes and socket state passed between bus target and event core
interface socket_reg_if;
  logic        wr_stb;
  logic [7:0]  wr_off;
  logic [31:0] wr_data;
  logic [3:0]  wr_be;
  logic [3:0]  event_q;
  logic [3:0]  mask_q;
  logic [5:0]  state_q;
  logic        irq_q;

  modport target (output wr_stb, wr_off, wr_data, wr_be, input event_q, mask_q, state_q, irq_q);
  modport core   (input wr_stb, wr_off, wr_data, wr_be, output event_q, mask_q, state_q, irq_q);
endinterface : socket_reg_if

//--- rtl/socket_event_core.sv
// Sticky socket event bits, mask and status-change interrupt
module socket_event_core
  import socket_pkg::*;
(
  input  wire logic  sys_clk,
  input  wire logic  rst,
  input  wire logic  card_detect_line_one,
  input  wire logic  card_detect_line_two,
  input  wire logic  card_status_state,
  input  wire logic  socket_powered_state,
  input  wire logic  card_is_16bit,
  input  wire logic  card_reset_active,
  socket_reg_if.core regs
);

  // ==========================================================
  // Input synchronisers
  // Order: reset, 16-bit, powered, detect two, detect one, status
  logic [5:0] meta_r;
  logic [5:0] sync_r;
  logic [5:0] prev_r;
  logic [3:0] event_r;
  logic [3:0] event_nxt;
  logic [3:0] mask_r;
  logic [3:0] mask_nxt;
  logic       irq_r;
  logic       irq_nxt;

  // Detect pair only counts when both halves are set
  function automatic logic [3:0] enable_vec(input logic [3:0] m);
    logic both;
    both = m[2] & m[1];
    enable_vec = {m[3], both, both, m[0]};
  endfunction : enable_vec

  always_comb begin
    logic [3:0] set_v;
    logic [3:0] clr_v;
    logic [5:0] chg;
    logic       csts_rise;
    logic       reset_exit;
    set_v      = 4'h0;
    clr_v      = 4'h0;
    chg        = sync_r ^ prev_r;
    csts_rise  = sync_r[0] & ~prev_r[0];
    reset_exit = prev_r[5] & ~sync_r[5];
    set_v[EVT_POWER_BIT] = chg[3];
    set_v[EVT_DET2_BIT]  = chg[2];
    set_v[EVT_DET1_BIT]  = chg[1];
    set_v[EVT_CSTS_BIT]  = sync_r[4] ? chg[0] : csts_rise;
    if (reset_exit) begin
      // Detect lines are low while a card sits in the socket
      set_v[EVT_CSTS_BIT] = set_v[EVT_CSTS_BIT] | sync_r[0];
      set_v[EVT_DET1_BIT] = set_v[EVT_DET1_BIT] | ~sync_r[1];
      set_v[EVT_DET2_BIT] = set_v[EVT_DET2_BIT] | ~sync_r[2];
    end
    mask_nxt = mask_r;
    if (regs.wr_stb && regs.wr_be[0]) begin
      if (regs.wr_off == SOCK_EVENT_OFF) begin
        clr_v = regs.wr_data[3:0];
      end else if (regs.wr_off == SOCK_FORCE_OFF) begin
        set_v = set_v | regs.wr_data[3:0];
      end else if (regs.wr_off == SOCK_MASK_OFF) begin
        mask_nxt = regs.wr_data[3:0];
      end
    end
    // A new event in the clearing cycle survives; mask never blocks it
    event_nxt = (event_r & ~clr_v) | set_v;
    irq_nxt   = |(event_nxt & enable_vec(mask_nxt));
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      meta_r  <= 6'h00;
      sync_r  <= 6'h00;
      prev_r  <= 6'h00;
      event_r <= EVT_RESET;
      mask_r  <= MASK_RESET;
      irq_r   <= 1'b0;
    end else begin
      meta_r  <= {card_reset_active, card_is_16bit, socket_powered_state,
                  card_detect_line_two, card_detect_line_one, card_status_state};
      sync_r  <= meta_r;
      prev_r  <= sync_r;
      event_r <= event_nxt;
      mask_r  <= mask_nxt;
      irq_r   <= irq_nxt;
    end
  end

  assign regs.event_q = event_r;
  assign regs.mask_q  = mask_r;
  assign regs.state_q = sync_r;
  assign regs.irq_q   = irq_r;

endmodule : socket_event_core

//--- tb/socket_event_assertions.sv
// Checker for bus handshake, read data and interrupt at the block's ports
module socket_event_assertions (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        frame_n,
  input wire logic        irdy_n,
  input wire logic [3:0]  cbe_n,
  input wire logic [31:0] ad_in,
  input wire logic [31:0] ad_out,
  input wire logic        ad_oe,
  input wire logic        trdy_n,
  input wire logic        trdy_oe,
  input wire logic        devsel_oe,
  input wire logic        par_out,
  input wire logic        par_oe,
  input wire logic        status_change_interrupt
);
  import socket_pkg::*;
  // ==========================================================
  // Address phase capture
  logic       frame_r, frame_nxt;
  logic [7:0] off_r, off_nxt;
  logic [3:0] cmd_r, cmd_nxt;
  logic       rd_evt, rd_low;

  always_comb begin
    frame_nxt = frame_n;
    off_nxt   = off_r;
    cmd_nxt   = cmd_r;
    if (!frame_n && frame_r) begin
      off_nxt = ad_in[7:0];
      cmd_nxt = cbe_n;
    end
  end

  always_ff @(posedge sys_clk) begin
    frame_r <= rst ? 1'b1 : frame_nxt;
    off_r   <= off_nxt;
    cmd_r   <= cmd_nxt;
  end

  assign rd_evt = ad_oe && cmd_r == CMD_MEM_RD && off_r == SOCK_EVENT_OFF;
  assign rd_low = ad_oe && cmd_r == CMD_MEM_RD && (off_r == SOCK_EVENT_OFF || off_r == SOCK_MASK_OFF);

  // ==========================================================
  // Properties
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence done_s; !trdy_n && trdy_oe && !irdy_n; endsequence
  sequence turn_s; trdy_n && trdy_oe ##1 !trdy_oe; endsequence

  chk_turn_release: assert property (done_s |=> turn_s)
    else $error("target strobes not turned and released");
  chk_parity_after: assert property ((ad_oe and done_s) |=> par_oe && par_out == ^{$past(ad_out), $past(cbe_n)})
    else $error("read parity wrong or missing");
  chk_upper_zero: assert property (rd_low |-> ad_out[31:4] == 28'h0)
    else $error("upper event or mask bits not zero");
  chk_irq_event: assert property (rd_evt && ad_out[3:0] == 4'h0 && $stable(status_change_interrupt)
                                  |-> !status_change_interrupt)
    else $error("interrupt high with no event set");
  chk_idle_release: assert property (frame_n && irdy_n && $past(frame_n) && $past(irdy_n) && $past(frame_n, 2)
                                     && $past(irdy_n, 2) |-> !devsel_oe)
    else $error("select driven on idle bus");
  chk_answer_time: assert property ($rose(devsel_oe) |-> $past(frame_n) == 1'b0 && $past(frame_n, 2))
    else $error("answer not one cycle after address");
  chk_data_with_trdy: assert property (ad_oe |-> !trdy_n && trdy_oe)
    else $error("read data driven without ready");
  chk_reset_quiet: assert property (@(posedge sys_clk) disable iff (1'b0)
                                    rst |=> !status_change_interrupt && !trdy_oe && !ad_oe)
    else $error("outputs active after reset");
endmodule : socket_event_assertions

//--- tb/socket_model.sv
// Socket-side lines standing in for the card and its power switch
module socket_model (
  input  wire logic sys_clk,
  output logic      card_detect_line_one,
  output logic      card_detect_line_two,
  output logic      card_status_state,
  output logic      socket_powered_state,
  output logic      card_is_16bit,
  output logic      card_reset_active
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Card present, powered down, 32-bit, out of reset
  initial {card_reset_active, card_is_16bit, socket_powered_state, card_detect_line_two,
           card_detect_line_one, card_status_state} = 6'h00;

  // Lines are asynchronous in the socket; moved just after an edge
  task automatic set_lines(input logic [5:0] v);
    @(posedge sys_clk);
    #1;
    {card_reset_active, card_is_16bit, socket_powered_state, card_detect_line_two,
     card_detect_line_one, card_status_state} = v;
  endtask : set_lines
endmodule : socket_model

//--- tb/tb_cardbus_socket_event_mask.sv
// Self-checking bench for the socket event, mask and force registers
module tb_cardbus_socket_event_mask;
  timeunit 1ns;
  timeprecision 1ns;
  import socket_pkg::*;
  // ==========================================================
  // Signals
  localparam logic [31:0] BASE = 32'h4000_0000;
  localparam logic [3:0]  MSK [4] = '{4'h1, 4'h6, 4'h6, 4'h8};
  logic        sys_clk = 1'b0, rst = 1'b1, frame_n = 1'b1, irdy_n = 1'b1, idsel = 1'b0;
  logic [3:0]  cbe_n = 4'hF, m;
  logic [31:0] ad_m = 32'h0, ad_in, ad_out;
  logic        ad_oe, trdy_n, trdy_oe, devsel_n, devsel_oe, stop_n, stop_oe, par_out, par_oe;
  logic        card_detect_line_one, card_detect_line_two, card_status_state, socket_powered_state;
  logic        card_is_16bit, card_reset_active, status_change_interrupt;
  logic [5:0]  lines = 6'h00;
  logic [31:0] exp_q [$];
  int          fails = 0, num_checks = 0, cycles = 0, seed = 98575, i;

  always #25 sys_clk = ~sys_clk;
  // Wire level: target drives while enabled, else the master
  assign ad_in = ad_oe ? ad_out : ad_m;

  cardbus_socket_event_mask u_cardbus_socket_event_mask (.sys_clk, .rst, .frame_n, .irdy_n, .idsel, .cbe_n,
    .ad_in, .ad_out, .ad_oe, .trdy_n, .trdy_oe, .devsel_n, .devsel_oe, .stop_n, .stop_oe, .par_out, .par_oe,
    .card_detect_line_one, .card_detect_line_two, .card_status_state, .socket_powered_state, .card_is_16bit,
    .card_reset_active, .status_change_interrupt);
  socket_model u_socket_model (.sys_clk, .card_detect_line_one, .card_detect_line_two, .card_status_state,
    .socket_powered_state, .card_is_16bit, .card_reset_active);

  // ==========================================================
  // Tasks
  task automatic check_val(input logic [31:0] seen, input logic [31:0] e);
    num_checks++;
    if (seen !== e) begin
      fails++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, e);
    end
  endtask : check_val

  task automatic final_report();
    if (fails == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report

  // Single data phase; released lines show the inverse of the data
  task automatic bus(input logic [3:0] cmd, input logic [31:0] addr, input logic [31:0] wd);
    int n;
    frame_n = 1'b0;
    cbe_n   = cmd;
    ad_m    = addr;
    idsel   = (cmd == CMD_CFG_RD || cmd == CMD_CFG_WR);
    @(posedge sys_clk);
    #1;
    frame_n = 1'b1;
    irdy_n  = 1'b0;
    cbe_n   = 4'h0;
    ad_m    = wd;
    idsel   = 1'b0;
    n = 0;
    while (trdy_n !== 1'b0 && n < 8) begin
      @(negedge sys_clk);
      n++;
    end
    @(posedge sys_clk);
    #1;
    irdy_n = 1'b1;
    cbe_n  = 4'hF;
    ad_m   = ~wd;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask : bus

  task automatic rdc(input logic [3:0] cmd, input logic [31:0] addr, input logic [31:0] e);
    exp_q.push_back(e);
    bus(cmd, addr, 32'h0);
  endtask : rdc
  task automatic rd(input logic [7:0] off, input logic [31:0] e);
    rdc(CMD_MEM_RD, BASE + {24'h0, off}, e);
  endtask : rd
  task automatic wr(input logic [7:0] off, input logic [31:0] d);
    bus(CMD_MEM_WR, BASE + {24'h0, off}, d);
  endtask : wr
  task automatic setup();
    bus(CMD_CFG_WR, {24'h0, CFG_BAR_OFF}, BASE);
    bus(CMD_CFG_WR, {24'h0, CFG_CMD_OFF}, 32'h2);
  endtask : setup
  // Sync plus edge detect settle well inside five edges
  task automatic lines_to(input logic [5:0] v);
    lines = v;
    u_socket_model.set_lines(v);
    repeat (5) @(posedge sys_clk);
    #1;
  endtask : lines_to

  // ==========================================================
  // Read watcher and timeout
  always @(posedge sys_clk) begin
    if (!rst && ad_oe === 1'b1 && trdy_n === 1'b0 && irdy_n === 1'b0) begin
      if (exp_q.size() > 0) check_val(ad_out, exp_q.pop_front());
      else check_val(ad_out, 32'hXXXX_XXXX);
    end
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      final_report();
    end
  end

  // ==========================================================
  // Scenarios
  initial begin
    repeat (4) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    setup();
    rdc(CMD_CFG_RD, {24'h0, CFG_BAR_OFF}, BASE);
    rd(SOCK_EVENT_OFF, 32'h0);
    wr(SOCK_EVENT_OFF, 32'hF);
    wr(SOCK_MASK_OFF, 32'hFFFF_FFFF);
    rd(SOCK_MASK_OFF, 32'hF);
    wr(SOCK_MASK_OFF, 32'h0);
    for (i = 0; i < 4; i++) begin
      lines_to(lines ^ (6'h1 << i));
      rd(SOCK_EVENT_OFF, 32'h1 << i);
      check_val({31'h0, status_change_interrupt}, 32'h0);
      wr(SOCK_EVENT_OFF, 32'h0);
      rd(SOCK_EVENT_OFF, 32'h1 << i);
      wr(SOCK_MASK_OFF, {28'h0, MSK[i]});
      check_val({31'h0, status_change_interrupt}, 32'h1);
      wr(SOCK_EVENT_OFF, 32'h1 << i);
      check_val({31'h0, status_change_interrupt}, 32'h0);
      rd(SOCK_EVENT_OFF, 32'h0);
      wr(SOCK_MASK_OFF, 32'h0);
    end
    lines_to(lines & 6'h3E);
    rd(SOCK_EVENT_OFF, 32'h0);
    lines_to(lines | 6'h10);
    for (i = 0; i < 2; i++) begin
      lines_to(lines ^ 6'h01);
      rd(SOCK_EVENT_OFF, 32'h1);
      wr(SOCK_EVENT_OFF, 32'h1);
    end
    lines_to(6'h39);
    wr(SOCK_EVENT_OFF, 32'hF);
    rd(SOCK_EVENT_OFF, 32'h0);
    lines_to(6'h19);
    rd(SOCK_EVENT_OFF, 32'h7);
    wr(SOCK_FORCE_OFF, 32'hF);
    rd(SOCK_EVENT_OFF, 32'hF);
    rd(SOCK_FORCE_OFF, 32'h0);
    rd(SOCK_STATE_OFF, 32'h3000_0019);
    for (i = 0; i < 4; i++) begin
      m = 4'($random(seed));
      m[1] = m[2];
      wr(SOCK_MASK_OFF, {28'h0, m});
      check_val({31'h0, status_change_interrupt}, {31'h0, m[3] | m[2] | m[0]});
    end
    wr(8'h14, 32'hFFFF_FFFF);
    rd(8'h14, 32'h0);
    rd(SOCK_PM_OFF, 32'h0);
    bus(CMD_MEM_RD, BASE + 32'h1000, 32'h0);
    lines_to(6'h10);
    rst = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    setup();
    rd(SOCK_EVENT_OFF, 32'h0);
    final_report();
  end
endmodule : tb_cardbus_socket_event_mask

bind cardbus_socket_event_mask socket_event_assertions u_socket_event_assertions (.sys_clk, .rst, .frame_n,
  .irdy_n, .cbe_n, .ad_in, .ad_out, .ad_oe, .trdy_n, .trdy_oe, .devsel_oe, .par_out, .par_oe,
  .status_change_interrupt);
